//--- verilog/ubf_top.sv
/*
 * Baud rate generator and FIFO mode interrupt logic of one serial channel,
 * with an APB register slave.
 * Assumes the receive and transmit FIFOs and shift registers sit beside it
 * on the same clock and report counts and events as plain inputs.
 */
// Operation
// RULE1: Divide reference clock by divisor 1 to 65535.
// RULE2: Generator output is sixteen times bit rate.
// RULE3: Divisor held in low and high byte latches.
// RULE4: Writing either divisor byte reloads the counter.
// RULE5: Divisor zero divides the clock by three.
// RULE6: Divisor one outputs the inverted reference clock.
// RULE7: Divisor two gives half rate, even duty.
// RULE8: Divisor three up: low two, high rest.
// RULE9: Reference clock nominally 1.8462 MHz.
// RULE10: High-speed bit: 32770 doubles, 32769 quadruples rate.
// RULE11: Data-available interrupt follows trigger level reached.
// RULE12: Line status outranks data-available identification.
// RULE13: Data ready sets on push, clears empty.
// RULE14: Timeout after four idle character times with data.
// RULE15: Character times counted from the sample clock.
// RULE16: Host read clears active timeout, restarts timer.
// RULE17: Otherwise receive or read restarts the timer.
// RULE18: Transmit empty interrupt; cleared by write, ident read.
// RULE19: Empty indication delayed after single byte use.
// RULE20: FIFO enable change raises transmit interrupt immediately; the code raises it only while transmit empty is already shown.
// RULE21: Timeout shares receive priority, empty shares transmit.
// RULE22: Divisor latches reachable only with access bit.
// RULE23: Overrun, parity, framing, break raise line interrupt.
// RULE24: Receive trigger level chosen by FIFO control.
`timescale 1ns/1ns
`default_nettype none
`include "ubf_map.svh"
module ubf_top #(
    parameter int DIV_W   = 16,
    parameter int COUNT_W = 5
) (
    input  wire logic               i_clk,
    input  wire logic               i_reset,
    input  wire logic               i_psel,
    input  wire logic               i_penable,
    input  wire logic               i_pwrite,
    input  wire logic [11:0]        i_paddr,
    input  wire logic [31:0]        i_pwdata,
    input  wire logic [COUNT_W-1:0] i_rx_count,
    input  wire logic               i_rx_char_done,
    input  wire logic [7:0]         i_rx_data,
    input  wire logic [3:0]         i_line_err,
    input  wire logic [COUNT_W-1:0] i_tx_count,
    output logic                    o_pready,
    output logic [31:0]             o_prdata,
    output logic                    o_pslverr,
    output logic                    o_baud16,
    output logic                    o_sample_tick,
    output logic                    o_irq,
    output logic                    o_rx_pop,
    output logic                    o_tx_push,
    output logic [7:0]              o_tx_data,
    output logic                    o_fifo_en,
    output logic                    o_rx_fifo_reset,
    output logic                    o_tx_fifo_reset,
    output logic [7:0]              o_line_ctrl
);
    import ubf_pkg::*;

    initial begin
        if (DIV_W != 16 || COUNT_W < 5) begin
            $error("ubf_top: DIV_W must be 16 and COUNT_W at least 5");
        end
    end

    // =================================================================
    // Reference clock from the system clock.
    localparam int HALF_CYC = `UBF_SYS_HZ / (2 * `UBF_REF_HZ);
    localparam logic [4:0] HALF_N = 5'(HALF_CYC);

    function automatic logic [7:0] trig_level(input logic [1:0] sel);
        case (sel)
            2'd0:    trig_level = 8'h01;
            2'd1:    trig_level = 8'h04;
            2'd2:    trig_level = 8'h08;
            default: trig_level = 8'h0e;
        endcase
    endfunction

    function automatic logic [3:0] char_bits(input logic [7:0] lc);
        char_bits = 4'd7 + {2'b00, lc[1:0]} + {3'b000, lc[`UBF_LINE_PAR]}
                  + {3'b000, lc[`UBF_LINE_STOP2]};
    endfunction

    logic [7:0]  div_lo_q;
    logic [7:0]  div_hi_q;
    logic [7:0]  irq_en_q;
    logic [7:0]  fifo_ctrl_q;
    logic [7:0]  line_ctrl_q;
    logic        hs_q;
    logic [4:0]  pre_q;
    logic        ref_q;
    logic        ref_rise;
    logic [15:0] cnt_q;
    logic [15:0] div_eff;
    logic [4:0]  half_lim;
    logic        div_wr;

    wire setup    = i_psel & ~i_penable;
    wire access   = i_psel & i_penable;
    wire [9:0] idx_full = i_paddr[11:2];
    wire [3:0] idx = idx_full[3:0];
    wire mapped   = (idx_full[9:4] == 6'h00) && (idx == `UBF_IDX_DATA || idx == `UBF_IDX_IRQEN
                    || idx == `UBF_IDX_IDENT || idx == `UBF_IDX_LINE || idx == `UBF_IDX_STATUS
                    || idx == `UBF_IDX_CONFIG);
    wire divisor_access_bit     = line_ctrl_q[`UBF_LINE_ACCESS];
    wire wr_acc   = access & i_pwrite & mapped;
    wire rd_acc   = access & ~i_pwrite & mapped;
    wire [15:0] divisor = {div_hi_q, div_lo_q};
    wire hs_sel   = hs_q & divisor[15]; // RULE10

    always_comb begin
        div_eff  = divisor;
        half_lim = HALF_N;
        if (hs_sel) begin // RULE10
            div_eff  = 16'h0001;
            half_lim = divisor[1] ? (HALF_N >> 1) : (HALF_N >> 2);
        end
    end

    assign ref_rise = (pre_q == 5'd0) & ~ref_q;
    assign div_wr   = wr_acc & divisor_access_bit & (idx == `UBF_IDX_DATA || idx == `UBF_IDX_IRQEN);

    // =================================================================
    // Reference clock phase at nominal rate, or faster with the high-speed bit.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pre_q <= 5'd0;
            ref_q <= 1'b0;
        end else if (pre_q == 5'd0) begin
            pre_q <= half_lim - 5'd1; // RULE9
            ref_q <= ~ref_q;
        end else begin
            pre_q <= pre_q - 5'd1;
        end
    end

    // =================================================================
    // Baud counter and sixteen times output.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cnt_q <= `UBF_RST_DIV;
        end else if (div_wr) begin
            cnt_q <= (div_eff == 16'h0000) ? 16'h0003 : div_eff; // RULE4
        end else if (ref_rise) begin
            if (cnt_q <= 16'h0001) begin
                cnt_q <= (div_eff == 16'h0000) ? 16'h0003 : div_eff; // RULE5 RULE1
            end else begin
                cnt_q <= cnt_q - 16'h0001;
            end
        end
    end

    logic baud_d;
    always_comb begin
        if (div_eff == 16'h0001) begin
            baud_d = ~ref_q; // RULE6
        end else if (div_eff == 16'h0002) begin
            baud_d = (cnt_q == 16'h0001); // RULE7
        end else begin
            baud_d = (cnt_q <= ((div_eff == 16'h0000) ? 16'h0001 : div_eff - 16'h0002)); // RULE8 RULE5
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_baud16      <= 1'b0;
            o_sample_tick <= 1'b0;
        end else begin
            o_baud16      <= baud_d; // RULE2
            o_sample_tick <= baud_d & ~o_baud16;
        end
    end

    // =================================================================
    // Host registers.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            div_lo_q    <= 8'(`UBF_RST_DIV);
            div_hi_q    <= `UBF_RST_BYTE;
            irq_en_q    <= `UBF_RST_BYTE;
            fifo_ctrl_q <= `UBF_RST_BYTE;
            line_ctrl_q <= `UBF_RST_BYTE;
            hs_q        <= 1'b0;
        end else if (wr_acc) begin
            case (idx)
                `UBF_IDX_DATA:   if (divisor_access_bit) div_lo_q <= i_pwdata[7:0]; // RULE3 RULE22
                `UBF_IDX_IRQEN:  if (divisor_access_bit) div_hi_q <= i_pwdata[7:0]; else irq_en_q <= {4'h0, i_pwdata[3:0]};
                `UBF_IDX_IDENT:  fifo_ctrl_q <= {i_pwdata[7:6], 5'h00, i_pwdata[0]}; // RULE24
                `UBF_IDX_LINE:   line_ctrl_q <= i_pwdata[7:0];
                `UBF_IDX_CONFIG: hs_q <= i_pwdata[`UBF_CFG_HS];
                default: ;
            endcase
        end
    end

    wire fifo_on   = fifo_ctrl_q[`UBF_FIFO_EN];
    wire fcr_wr    = wr_acc & (idx == `UBF_IDX_IDENT);
    wire fen_chg   = fcr_wr & (i_pwdata[`UBF_FIFO_EN] != fifo_on);
    wire rx_read   = rd_acc & ~divisor_access_bit & (idx == `UBF_IDX_DATA);
    wire thr_write = wr_acc & ~divisor_access_bit & (idx == `UBF_IDX_DATA);
    wire iir_read  = rd_acc & (idx == `UBF_IDX_IDENT);
    wire lsr_read  = rd_acc & (idx == `UBF_IDX_STATUS);
    wire [7:0] rx_cnt8 = 8'(i_rx_count);

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_rx_pop        <= 1'b0;
            o_tx_push       <= 1'b0;
            o_tx_data       <= 8'h00;
            o_rx_fifo_reset <= 1'b0;
            o_tx_fifo_reset <= 1'b0;
        end else begin
            o_rx_pop        <= rx_read;
            o_tx_push       <= thr_write;
            o_rx_fifo_reset <= fcr_wr & (i_pwdata[`UBF_FIFO_RXRST] | fen_chg);
            o_tx_fifo_reset <= fcr_wr & (i_pwdata[`UBF_FIFO_TXRST] | fen_chg);
            if (thr_write) begin
                o_tx_data <= i_pwdata[7:0];
            end
        end
    end

    // =================================================================
    // Line errors and data ready.
    logic [3:0] err_q;
    logic       ready_q;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            err_q   <= 4'h0;
            ready_q <= 1'b0;
        end else begin
            err_q <= (lsr_read ? 4'h0 : err_q) | i_line_err; // RULE23
            if (i_rx_char_done) begin
                ready_q <= 1'b1; // RULE13
            end else if (i_rx_count == '0) begin
                ready_q <= 1'b0; // RULE13
            end
        end
    end

    // =================================================================
    // Receive timeout, counted in sample ticks.
    logic [11:0] tout_q;
    logic        tout_act_q;
    wire  [11:0] tout_lim = 12'(`UBF_TIMEOUT_CH) * {4'h0, char_bits(line_ctrl_q), 4'h0};
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            tout_q     <= 12'h000;
            tout_act_q <= 1'b0;
        end else if (rx_read) begin
            tout_q     <= 12'h000; // RULE16 RULE17
            tout_act_q <= 1'b0;
        end else if (i_rx_char_done || i_rx_count == '0 || !fifo_on) begin
            tout_q <= 12'h000; // RULE17
            if (i_rx_count == '0 || !fifo_on) begin
                tout_act_q <= 1'b0;
            end
        end else if (o_sample_tick && !tout_act_q) begin
            if (tout_q >= tout_lim - 12'h001) begin
                tout_act_q <= 1'b1; // RULE14 RULE15
            end else begin
                tout_q <= tout_q + 12'h001;
            end
        end
    end

    // =================================================================
    // Transmit empty indication with delay.
    ubf_tx_state_e tx_state_q;
    logic [7:0]    tx_dly_q;
    logic          two_seen_q;
    logic          thr_irq_q;
    wire  tx_empty = (i_tx_count == '0);
    wire  [7:0] dly_lim = {char_bits(line_ctrl_q) - 4'd1, 4'h0};
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            tx_state_q <= UBF_TX_SHOWN;
            tx_dly_q   <= 8'h00;
            two_seen_q <= 1'b0;
        end else begin
            if (i_tx_count >= COUNT_W'(2)) begin
                two_seen_q <= 1'b1;
            end
            case (tx_state_q)
                UBF_TX_IDLE: begin
                    if (tx_empty) begin
                        tx_dly_q <= 8'h00;
                        if (two_seen_q || !fifo_on) begin
                            tx_state_q <= UBF_TX_SHOWN;
                        end else begin
                            tx_state_q <= UBF_TX_DELAY; // RULE19
                        end
                    end
                end
                UBF_TX_DELAY: begin
                    if (!tx_empty) begin
                        tx_state_q <= UBF_TX_IDLE;
                    end else if (o_sample_tick) begin
                        if (tx_dly_q >= dly_lim - 8'h01) begin
                            tx_state_q <= UBF_TX_SHOWN; // RULE19
                        end else begin
                            tx_dly_q <= tx_dly_q + 8'h01;
                        end
                    end
                end
                UBF_TX_SHOWN: begin
                    if (!tx_empty) begin
                        tx_state_q <= UBF_TX_IDLE;
                        two_seen_q <= 1'b0;
                    end
                end
                default: tx_state_q <= UBF_TX_SHOWN;
            endcase
        end
    end

    wire thr_shown = (tx_state_q == UBF_TX_SHOWN) & tx_empty;
    logic shown_q;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            shown_q   <= 1'b1;
            thr_irq_q <= 1'b0;
        end else begin
            shown_q <= thr_shown;
            if ((thr_shown && !shown_q) || (fen_chg && thr_shown)) begin
                thr_irq_q <= 1'b1; // RULE18 RULE20
            end else if (thr_write || iir_read) begin
                thr_irq_q <= 1'b0; // RULE18
            end
        end
    end

    // =================================================================
    // Interrupt identification and priority.
    wire src_line = irq_en_q[`UBF_IE_LINE] & (err_q != 4'h0);
    wire src_rda  = irq_en_q[`UBF_IE_RX] & (fifo_on ? (rx_cnt8 >= trig_level(fifo_ctrl_q[7:6]))
                    : ready_q); // RULE11 RULE24
    wire src_tout = irq_en_q[`UBF_IE_RX] & fifo_on & tout_act_q; // RULE14
    wire src_thr  = irq_en_q[`UBF_IE_TX] & thr_irq_q;
    ubf_ident_t ident;
    always_comb begin
        if (src_line) begin
            ident = UBF_ID_LINE; // RULE12
        end else if (src_rda) begin
            ident = UBF_ID_RDA; // RULE21
        end else if (src_tout) begin
            ident = UBF_ID_TOUT; // RULE21
        end else if (src_thr) begin
            ident = UBF_ID_THR; // RULE21
        end else begin
            ident = UBF_ID_NONE;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= (ident != UBF_ID_NONE);
        end
    end

    // =================================================================
    // APB read data, captured in the setup phase.
    logic [7:0] rd_d;
    always_comb begin
        case (idx)
            `UBF_IDX_DATA:   rd_d = divisor_access_bit ? div_lo_q : i_rx_data;
            `UBF_IDX_IRQEN:  rd_d = divisor_access_bit ? div_hi_q : irq_en_q;
            `UBF_IDX_IDENT:  rd_d = {fifo_on, fifo_on, 2'b00, ident};
            `UBF_IDX_LINE:   rd_d = line_ctrl_q;
            `UBF_IDX_STATUS: rd_d = {fifo_on & (err_q[3:1] != 3'h0), thr_shown & (i_tx_count == '0),
                                     thr_shown, err_q, ready_q};
            `UBF_IDX_CONFIG: rd_d = {7'h00, hs_q};
            default:         rd_d = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= setup;
            o_pslverr <= setup & ~mapped;
            if (setup) begin
                o_prdata <= (mapped && !i_pwrite) ? {24'h00_0000, rd_d} : 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_fifo_en   <= 1'b0;
            o_line_ctrl <= 8'h00;
        end else begin
            o_fifo_en   <= fifo_on;
            o_line_ctrl <= line_ctrl_q;
        end
    end
endmodule
`default_nettype wire

//--- verilog/ubf_map.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * serial port baud and interrupt block.
 * Assumes inclusion by the block's top module.
 */
`ifndef UBF_MAP_SVH
`define UBF_MAP_SVH
// =====================================================================
// Register indices; the byte address is four times the index.
`define UBF_IDX_DATA    4'h0
`define UBF_IDX_IRQEN   4'h1
`define UBF_IDX_IDENT   4'h2
`define UBF_IDX_LINE    4'h3
`define UBF_IDX_STATUS  4'h5
`define UBF_IDX_CONFIG  4'h8
// =====================================================================
// Field positions.
`define UBF_LINE_ACCESS 7
`define UBF_LINE_STOP2  2
`define UBF_LINE_PAR    3
`define UBF_FIFO_EN     0
`define UBF_FIFO_RXRST  1
`define UBF_FIFO_TXRST  2
`define UBF_IE_RX       0
`define UBF_IE_TX       1
`define UBF_IE_LINE     2
`define UBF_CFG_HS      0
// =====================================================================
// Reset values.
`define UBF_RST_DIV     16'h000c
`define UBF_RST_BYTE    8'h00
// =====================================================================
// Timing: system clock and nominal reference clock in Hz.
`define UBF_SYS_HZ      50000000
`define UBF_REF_HZ      1846200
`define UBF_TIMEOUT_CH  4
`endif

//--- verilog/ubf_pkg.sv
/*
 * Types shared by the serial port baud and interrupt block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ubf_pkg;
    typedef enum logic [2:0] {
        UBF_TX_IDLE  = 3'b001,
        UBF_TX_DELAY = 3'b010,
        UBF_TX_SHOWN = 3'b100
    } ubf_tx_state_e;
    typedef logic [3:0] ubf_ident_t;
    localparam ubf_ident_t UBF_ID_NONE = 4'h1;
    localparam ubf_ident_t UBF_ID_LINE = 4'h6;
    localparam ubf_ident_t UBF_ID_RDA  = 4'h4;
    localparam ubf_ident_t UBF_ID_TOUT = 4'hc;
    localparam ubf_ident_t UBF_ID_THR  = 4'h2;
endpackage

//--- test/ubf_chk.sv
/*
 * Port checker for the serial baud and interrupt block.
 * Assumes it is bound to every ubf_top instance.
 */
`timescale 1ns/1ns
`default_nettype none
module ubf_chk (
    input wire logic        i_clk,
    input wire logic        i_reset,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic        o_pready,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pslverr,
    input wire logic        o_sample_tick,
    input wire logic        o_rx_pop,
    input wire logic        o_tx_push,
    input wire logic [7:0]  o_tx_data,
    input wire logic        o_fifo_en,
    input wire logic        o_rx_fifo_reset,
    input wire logic        o_tx_fifo_reset,
    input wire logic [7:0]  o_line_ctrl
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    wire acc = i_psel && i_penable && o_pready;
    wire wr8 = acc && i_pwrite && i_paddr == 12'h008;
    // =========================================================
    // Assertions.
    AST_READY: assert property (i_psel && !i_penable |=> o_pready)
        else $error("no ready after setup");
    AST_READY_ONE: assert property (o_pready |=> !o_pready)
        else $error("ready held too long");
    AST_UNMAPPED: assert property (i_psel && !i_penable && i_paddr == 12'h010 |=> o_pslverr)
        else $error("no error on unmapped access");
    AST_UPPER: assert property (o_pready |-> o_prdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    AST_TICK: assert property (o_sample_tick |=> !o_sample_tick [*8])
        else $error("sample tick too close");
    AST_POP: assert property (acc && !i_pwrite && i_paddr == 12'h000 && !o_line_ctrl[7] |=> o_rx_pop)
        else $error("data read gave no pop");
    AST_NOPOP: assert property (acc && i_paddr == 12'h000 && o_line_ctrl[7] |=> !o_rx_pop && !o_tx_push)
        else $error("divisor access touched fifo");
    AST_PUSH: assert property (acc && i_pwrite && i_paddr == 12'h000 && !o_line_ctrl[7]
        |=> o_tx_push && o_tx_data == $past(i_pwdata[7:0]))
        else $error("data write gave wrong push");
    AST_FEN: assert property (wr8 |=> ##1 o_fifo_en == $past(i_pwdata[0], 2))
        else $error("fifo enable not taken");
    AST_FRST: assert property (wr8 && i_pwdata[0] != o_fifo_en |=> o_rx_fifo_reset && o_tx_fifo_reset)
        else $error("no fifo reset on enable change");
    AST_LCR: assert property (acc && i_pwrite && i_paddr == 12'h00c
        |=> ##1 o_line_ctrl == $past(i_pwdata[7:0], 2))
        else $error("line control not taken");
endmodule
bind ubf_top ubf_chk u_chk (.i_clk(i_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
    .o_pslverr(o_pslverr), .o_sample_tick(o_sample_tick), .o_rx_pop(o_rx_pop), .o_tx_push(o_tx_push),
    .o_tx_data(o_tx_data), .o_fifo_en(o_fifo_en), .o_rx_fifo_reset(o_rx_fifo_reset),
    .o_tx_fifo_reset(o_tx_fifo_reset), .o_line_ctrl(o_line_ctrl));
`default_nettype wire

//--- test/ubf_peer.sv
/*
 * Model of the receive and transmit FIFOs beside the block.
 * Assumes the bench pulses i_put to deliver a received byte.
 */
`timescale 1ns/1ns
`default_nettype none
module ubf_peer (
    input wire logic       i_clk,
    input wire logic       i_reset,
    input wire logic       i_put,
    input wire logic [7:0] i_byte,
    input wire logic       i_rx_pop,
    input wire logic       i_tx_push,
    input wire logic       i_rx_rst,
    input wire logic       i_tx_rst,
    output logic [4:0]     o_rx_count,
    output logic           o_rx_done,
    output logic [7:0]     o_rx_data,
    output logic [4:0]     o_tx_count
);
    logic [7:0] q[$];
    int         drain;
    initial begin
        o_rx_count = 0;
        o_rx_done = 0;
        o_rx_data = 0;
        o_tx_count = 0;
        drain = 0;
    end
    // =========================================================
    // Receive queue; an empty queue shows changing data.
    always @(posedge i_clk) begin
        o_rx_done <= 1'b0;
        if (i_reset || i_rx_rst) begin
            q = {};
        end else begin
            if (i_rx_pop && q.size() > 0) q.pop_front();
            if (i_put) begin
                q.push_back(i_byte);
                o_rx_done <= 1'b1;
            end
        end
        o_rx_count <= 5'(q.size());
        o_rx_data <= (q.size() > 0) ? q[0] : ~o_rx_data;
    end
    // =========================================================
    // Transmit side sends one byte every 64 cycles.
    always @(posedge i_clk) begin
        if (i_reset || i_tx_rst) begin
            o_tx_count <= 0;
            drain = 0;
        end else if (i_tx_push) begin
            o_tx_count <= o_tx_count + 5'h01;
        end else if (o_tx_count != 0) begin
            drain++;
            if (drain == 64) begin
                o_tx_count <= o_tx_count - 5'h01;
                drain = 0;
            end
        end
    end
endmodule
`default_nettype wire

//--- test/tb_top.sv
/*
 * Self-checking bench for the serial baud and interrupt block.
 * Assumes ubf_peer stands in for the FIFOs and ubf_chk is bound.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, put = 0, err;
    logic [11:0] pa = 0;
    logic [31:0] pwd = 0, q, prd;
    logic [3:0]  lerr = 0;
    logic [7:0]  pb = 0, txd, lcr, rxdat;
    logic        rdy, perr, b16, tick, irq, pop, push, fen, rxr, txr, rxd;
    logic [4:0]  rxc, txc;
    int          n_fail = 0, cmp_count = 0, hi, lo, t;
    int          dv[5] = '{12, 3, 2, 1, 0};
    int          ep[5] = '{312, 78, 52, 26, 78};
    int          el[5] = '{52, 52, 26, 13, 0};
    int          lv[4] = '{1, 4, 8, 14};
    always #10 clk = ~clk;
    ubf_top DUT (.i_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(pa), .i_pwdata(pwd), .i_rx_count(rxc), .i_rx_char_done(rxd), .i_rx_data(rxdat),
        .i_line_err(lerr), .i_tx_count(txc), .o_pready(rdy), .o_prdata(prd), .o_pslverr(perr),
        .o_baud16(b16), .o_sample_tick(tick), .o_irq(irq), .o_rx_pop(pop), .o_tx_push(push),
        .o_tx_data(txd), .o_fifo_en(fen), .o_rx_fifo_reset(rxr), .o_tx_fifo_reset(txr), .o_line_ctrl(lcr));
    ubf_peer PEER (.i_clk(clk), .i_reset(rst), .i_put(put), .i_byte(pb), .i_rx_pop(pop), .i_tx_push(push),
        .i_rx_rst(rxr), .i_tx_rst(txr), .o_rx_count(rxc), .o_rx_done(rxd), .o_rx_data(rxdat), .o_tx_count(txc));
    // =========================================================
    // Shared tasks.
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask
    task tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= d;
        @(posedge clk);
        pen <= 1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (rdy === 1'b1) break;
        end
        if (i == 16) begin
            n_fail++;
            tally_and_finish;
        end
        q = prd;
        err = perr;
        psel <= 0; pen <= 0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
        apb(0, a, 0);
        chk(nm, e, q);
    endtask
    task give(input logic [7:0] b);
        @(posedge clk);
        put <= 1; pb <= b;
        @(posedge clk);
        put <= 0;
    endtask
    task edge_to(input logic v);
        int i;
        for (i = 0; i < 4000 && b16 !== v; i++) @(negedge clk);
    endtask
    task ticks(input int n);
        int c;
        c = 0;
        while (c < n) begin
            @(negedge clk);
            if (tick === 1'b1) c++;
        end
    endtask
    initial begin
        #1800000;
        n_fail++;
        tally_and_finish;
    end
    // =========================================================
    // Main sequence.
    initial begin
        repeat (16) @(posedge clk);
        rst <= 0;
        rd(12'h00c, 0, "line_ctrl");
        rd(12'h008, 32'h01, "ident_reset");
        rd(12'h010, 0, "unmapped");
        chk("slverr", 1, err);
        apb(1, 12'h00c, 32'h80);
        rd(12'h000, 32'h0c, "div_low");
        rd(12'h004, 0, "div_high");
        $display("test registers done");
        for (int k = 0; k < 5; k++) begin
            apb(1, 12'h000, dv[k]);
            edge_to(0); edge_to(1); edge_to(0); edge_to(1);
            hi = 0; lo = 0;
            while (b16 === 1'b1 && hi < 4000) begin @(negedge clk); hi++; end
            while (b16 === 1'b0 && lo < 4000) begin @(negedge clk); lo++; end
            chk("period", ep[k], hi + lo);
            if (k != 4) chk("low_time", el[k], lo);
        end
        apb(1, 12'h000, 32'h01);
        apb(1, 12'h00c, 0);
        $display("test baud done");
        apb(1, 12'h008, 32'h01);
        apb(1, 12'h004, 32'h05);
        give(8'h5a);
        rd(12'h008, 32'hc4, "ident_rda");
        chk("irq_rda", 1, irq);
        rd(12'h000, 32'h5a, "rx_data");
        rd(12'h008, 32'hc1, "ident_clear");
        for (int b = 0; b < 4; b++) begin
            @(posedge clk); lerr <= 4'(1 << b);
            @(posedge clk); lerr <= 0;
            rd(12'h008, 32'hc6, "ident_line");
            apb(0, 12'h014, 0);
        end
        give(8'ha5);
        @(posedge clk); lerr <= 4'h2;
        @(posedge clk); lerr <= 0;
        rd(12'h008, 32'hc6, "ident_prio");
        apb(0, 12'h014, 0);
        rd(12'h008, 32'hc4, "ident_after");
        rd(12'h000, 32'ha5, "rx_data2");
        $display("test receive done");
        for (int s = 0; s < 4; s++) begin
            apb(1, 12'h008, {24'h0, 2'(s), 6'h01});
            repeat (lv[s] - 1) give(8'(s));
            rd(12'h008, 32'hc1, "below_level");
            give(8'h77);
            rd(12'h008, 32'hc4, "at_level");
            repeat (lv[s]) apb(0, 12'h000, 0);
        end
        $display("test levels done");
        apb(1, 12'h008, 32'h41);
        give(8'h01);
        give(8'h02);
        ticks(300);
        rd(12'h000, 32'h01, "rx_early");
        t = 0;
        while (irq !== 1'b1 && t < 600) begin
            @(negedge clk);
            if (tick === 1'b1) t++;
        end
        cmp_count++;
        if (t < 440 || t > 456) begin
            $display("[ERR] timeout_ticks expected 448 seen %0d", t);
            n_fail++;
        end
        rd(12'h008, 32'hcc, "ident_tout");
        rd(12'h000, 32'h02, "rx_tout");
        rd(12'h008, 32'hc1, "ident_tout_clr");
        $display("test timeout done");
        apb(1, 12'h004, 32'h02);
        apb(1, 12'h008, 0);
        apb(1, 12'h008, 32'h01);
        rd(12'h008, 32'hc2, "ident_thr");
        rd(12'h008, 32'hc1, "ident_thr_clr");
        apb(1, 12'h000, 32'h33);
        $display("test transmit done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
